// File: shared/ssp_pkg.sv
package ssp_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_ISTAT = 8'h0C;
  localparam logic [7:0] OFF_ICLR = 8'h10;
  localparam logic [7:0] OFF_IEN = 8'h14;

  // Field positions in the first control register.
  localparam int MODE_LSB = 5;
  localparam int UNUSED_BIT = 4;
  localparam int ON_BIT = 1;
  localparam int INC_BIT = 0;

  // Field positions in the third control register.
  localparam int POL_BIT = 5;
  localparam int EDGE_BIT = 4;
  localparam int ORDER_BIT = 3;
  localparam int SELECT_PIN_ENABLE_BIT = 2;
  localparam int WRITE_COLLISION_FLAG_BIT = 1;
  localparam int TRF_BIT = 0;

  // Interrupt status, clear and enable bit positions.
  localparam int INT_DONE = 0;
  localparam int INT_COLL = 1;
  localparam int INT_INC = 2;

  // Reset values.
  localparam logic [7:0] CTRL0_RST = 8'hE0;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] IEN_RST = 3'h0;

  // Half periods of the master clock in system clocks, and edges per byte.
  localparam logic [5:0] DIV4_HALF = 6'(4 / 2);
  localparam logic [5:0] DIV16_HALF = 6'(16 / 2);
  localparam logic [5:0] DIV64_HALF = 6'(64 / 2);
  localparam logic [4:0] EDGE_TOTAL = 5'(2 * 8);

  typedef enum logic [2:0] {
    SSP_DIV4 = 3'h0,
    SSP_DIV16 = 3'h1,
    SSP_DIV64 = 3'h2,
    SSP_TBASE = 3'h3,
    SSP_TMATCH = 3'h4,
    SSP_SLAVE = 3'h5,
    SSP_TWOWIRE = 3'h6,
    SSP_OFF = 3'h7
  } ssp_mode_t;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'h0,
    SSP_RUN = 2'h1
  } ssp_phase_t;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
    logic sck;
    logic sck_oe;
    logic ss_n;
    logic ss_oe;
  } ssp_pins_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl2;
    logic [7:0] shreg;
    logic samp;
    logic pend;
    ssp_phase_t phase;
    logic [4:0] edges;
    logic [5:0] div;
    logic sck_lvl;
    logic sck_prev;
    logic ss_prev;
    logic [2:0] ist;
    logic [2:0] ien;
    ssp_pins_t pins;
    logic irq;
    logic [7:0] prdata;
    logic pready;
    logic pslverr;
  } ssp_state_t;

endpackage

// File: verilog/ssp_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for pin levels; only the second stage is read.
module ssp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ssp_sync_state_t;

  ssp_sync_state_t s;
  ssp_sync_state_t next_s;

  initial begin
    if (WIDTH < 1) begin
      $error("ssp_sync needs at least one bit.");
    end
  end

  // The first stage feeds the second stage and nothing else.
  always_comb begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule // ssp_sync

// File: verilog/ssp_port.sv
`timescale 1ns/1ps
module ssp_port #(
  parameter int ADDR_W = 8
) (
  input wire logic MCLK_IN, // System clock, 25 MHz.
  input wire logic RST_IN, // Synchronous reset, active high.
  input wire logic PSEL_IN, // APB select.
  input wire logic PENABLE_IN, // APB enable.
  input wire logic PWRITE_IN, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] PADDR_IN, // APB byte address.
  input wire logic [31:0] PWDATA_IN, // APB write data.
  output logic [31:0] PRDATA_OUT, // APB read data.
  output logic PREADY_OUT, // APB ready.
  output logic PSLVERR_OUT, // APB error on unmapped address.
  input wire logic PIN_FUNC_SEL_IN, // Shared pins assigned to this port.
  input wire logic TIMEBASE_TICK_IN, // Timebase pulse, one half period each.
  input wire logic TIMER_MATCH_IN, // Timer match pulse.
  input wire logic SDI_IN, // Serial data in pin.
  input wire logic SCK_IN, // Serial clock pin level.
  input wire logic SLAVE_SELECT_N_IN, // Select pin level, active low.
  output logic SDO_OUT, // Serial data out.
  output logic SDO_OE_OUT, // Serial data out enable.
  output logic SCK_OUT, // Serial clock out.
  output logic SCK_OE_OUT, // Serial clock out enable.
  output logic SLAVE_SELECT_N_OUT, // Select out, active low.
  output logic SLAVE_SELECT_N_OE_OUT, // Select out enable.
  output logic IRQ_OUT // Interrupt, high while an enabled event is set.
);

  ssp_pkg::ssp_state_t s;
  ssp_pkg::ssp_state_t next_s;
  logic [2:0] pin_sync;
  logic sdi_s;
  logic sck_s;
  logic ss_s;

  initial begin
    if (ADDR_W < 5 || ADDR_W > 32) begin
      $error("ssp_port address width must be 5 to 32.");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops before any logic reads them.
  ssp_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .async_in({SDI_IN, SCK_IN, SLAVE_SELECT_N_IN}),
    .sync_out(pin_sync)
  );
  assign sdi_s = pin_sync[2];
  assign sck_s = pin_sync[1];
  assign ss_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Shift one received bit in; the bit leaving is the one on data out.
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

  // One clock edge: capture on the chosen edge, shift on the next edge.
  function automatic logic [9:0] edge_step(input logic [7:0] sh, input logic samp,
                                           input logic pend, input logic sdi,
                                           input logic cap, input logic msb);
    edge_step = {sh, samp, pend};
    if (cap) begin
      edge_step = {sh, sdi, 1'h1};
    end else if (pend) begin
      edge_step = {shift_in(sh, samp, msb), samp, 1'h0};
    end
  endfunction

  // Master half-period tick for each clock source.
  function automatic logic half_tick(input logic [2:0] mode, input logic [5:0] div,
                                     input logic tb, input logic tm);
    half_tick = 1'h0;
    case (mode)
      ssp_pkg::SSP_DIV4: half_tick = (div == ssp_pkg::DIV4_HALF - 6'h1);
      ssp_pkg::SSP_DIV16: half_tick = (div == ssp_pkg::DIV16_HALF - 6'h1);
      ssp_pkg::SSP_DIV64: half_tick = (div == ssp_pkg::DIV64_HALF - 6'h1);
      ssp_pkg::SSP_TBASE: half_tick = tb;
      ssp_pkg::SSP_TMATCH: half_tick = tm; // Two matches make one period.
      default: half_tick = 1'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] mode;
  logic on;
  logic master;
  logic slave;
  logic spi_on;
  logic idle;
  logic msb;
  logic lead_cap;
  logic sel;
  logic busy;
  logic hstep;
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic ev_done;
  logic ev_coll;
  logic ev_inc;
  logic [9:0] es;

  // Next state: bus slave, engine, flags, pins and interrupt.
  always_comb begin
    next_s = s;
    es = '0;
    ev_done = 1'h0;
    ev_coll = 1'h0;
    ev_inc = 1'h0;
    mode = s.ctrl0[ssp_pkg::MODE_LSB +: 3];
    on = s.ctrl0[ssp_pkg::ON_BIT];
    master = (mode <= ssp_pkg::SSP_TMATCH);
    slave = (mode == ssp_pkg::SSP_SLAVE);
    spi_on = on & (master | slave);
    idle = ~s.ctrl2[ssp_pkg::POL_BIT];
    msb = s.ctrl2[ssp_pkg::ORDER_BIT];
    lead_cap = s.ctrl2[ssp_pkg::EDGE_BIT];
    sel = ~s.ctrl2[ssp_pkg::SELECT_PIN_ENABLE_BIT] | ~ss_s;
    busy = (s.phase == ssp_pkg::SSP_RUN) | (slave & (s.edges != 5'h0));
    hstep = half_tick(mode, s.div, TIMEBASE_TICK_IN, TIMER_MATCH_IN);
    wd = PWDATA_IN[7:0];
    acc = PSEL_IN & PENABLE_IN & s.pready;
    wr = acc & PWRITE_IN;

    // One wait state, so read data and ready both come from flip-flops.
    next_s.pready = PSEL_IN & PENABLE_IN & ~s.pready;
    next_s.pslverr = 1'h0;
    next_s.prdata = 8'h00;
    if (PSEL_IN & PENABLE_IN & ~s.pready) begin
      if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_CTRL0)) begin
        next_s.prdata = s.ctrl0;
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_CTRL2)) begin
        next_s.prdata = s.ctrl2;
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_DATA)) begin
        next_s.prdata = s.shreg;
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_ISTAT)) begin
        next_s.prdata = {5'h00, s.ist};
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_IEN)) begin
        next_s.prdata = {5'h00, s.ien};
      end else if (PADDR_IN != ADDR_W'(ssp_pkg::OFF_ICLR)) begin
        next_s.pslverr = 1'h1; // No second control register here
      end
    end

    // Software writes come first so that hardware events below win.
    if (wr) begin
      if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_CTRL0)) begin
        next_s.ctrl0 = wd;
        next_s.ctrl0[ssp_pkg::UNUSED_BIT] = 1'h0;
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_CTRL2)) begin
        next_s.ctrl2 = wd;
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_DATA)) begin
        if (busy) begin
          ev_coll = 1'h1; // Data is dropped
        end else begin
          next_s.shreg = wd;
          next_s.pend = 1'h0;
          if (spi_on & master) begin
            next_s.phase = ssp_pkg::SSP_RUN;
            next_s.edges = 5'h0;
            next_s.div = 6'h0;
          end
        end
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_ICLR)) begin
        next_s.ist = s.ist & ~wd[2:0];
      end else if (PADDR_IN == ADDR_W'(ssp_pkg::OFF_IEN)) begin
        next_s.ien = wd[2:0];
      end
    end

    // Master engine; the slave engine runs from the synchronised pins.
    next_s.sck_prev = sck_s;
    next_s.ss_prev = ss_s;
    if (~spi_on) begin
      next_s.phase = ssp_pkg::SSP_IDLE; // Configuration bits stay
      next_s.edges = 5'h0;
      next_s.sck_lvl = idle;
    end else if (master) begin
      if (s.phase == ssp_pkg::SSP_IDLE) begin
        next_s.sck_lvl = idle;
      end else begin
        next_s.div = hstep ? 6'h0 : s.div + 6'h1;
        if (hstep && s.edges == ssp_pkg::EDGE_TOTAL) begin
          if (s.pend) begin
            next_s.shreg = shift_in(s.shreg, s.samp, msb);
            next_s.pend = 1'h0;
          end
          next_s.phase = ssp_pkg::SSP_IDLE;
          next_s.edges = 5'h0;
          ev_done = 1'h1;
        end else if (hstep) begin
          next_s.sck_lvl = ~s.sck_lvl;
          es = edge_step(s.shreg, s.samp, s.pend, sdi_s,
                         (s.edges[0] == 1'h0) == lead_cap, msb);
          {next_s.shreg, next_s.samp, next_s.pend} = es;
          next_s.edges = s.edges + 5'h1;
        end
      end
    end else begin
      // The slave only follows edges from the external master
      // A master byte cut short by a role change ends here without a flag.
      next_s.sck_lvl = idle;
      if (s.phase == ssp_pkg::SSP_RUN) begin
        next_s.phase = ssp_pkg::SSP_IDLE;
        next_s.edges = 5'h0;
      end else if (~sel) begin
        if (s.edges != 5'h0) begin
          ev_inc = 1'h1; // Select lifted mid byte.
          ev_done = 1'h1;
        end
        next_s.edges = 5'h0;
        next_s.pend = 1'h0;
      end else if (sck_s != s.sck_prev) begin
        es = edge_step(s.shreg, s.samp, s.pend, sdi_s,
                       (sck_s != idle) == lead_cap, msb);
        {next_s.shreg, next_s.samp, next_s.pend} = es;
        next_s.edges = s.edges + 5'h1;
        if (s.edges == ssp_pkg::EDGE_TOTAL - 5'h1) begin
          if (es[0]) begin
            next_s.shreg = shift_in(es[9:2], es[1], msb);
            next_s.pend = 1'h0;
          end
          next_s.edges = 5'h0;
          ev_done = 1'h1;
        end
      end
    end

    // Hardware sets win over a clear written in the same cycle.
    if (ev_done) begin
      next_s.ctrl2[ssp_pkg::TRF_BIT] = 1'h1;
      next_s.ist[ssp_pkg::INT_DONE] = 1'h1;
    end
    if (ev_coll) begin
      next_s.ctrl2[ssp_pkg::WRITE_COLLISION_FLAG_BIT] = 1'h1;
      next_s.ist[ssp_pkg::INT_COLL] = 1'h1;
    end
    if (ev_inc) begin
      next_s.ctrl0[ssp_pkg::INC_BIT] = 1'h1;
      next_s.ist[ssp_pkg::INT_INC] = 1'h1;
    end

    // Pin drive depends on pin select, role, select enable and enable.
    next_s.pins.sdo = msb ? next_s.shreg[7] : next_s.shreg[0];
    next_s.pins.sdo_oe = PIN_FUNC_SEL_IN & spi_on & (master | sel);
    next_s.pins.sck = next_s.sck_lvl;
    next_s.pins.sck_oe = PIN_FUNC_SEL_IN & spi_on & master;
    next_s.pins.ss_n = (next_s.phase == ssp_pkg::SSP_IDLE);
    next_s.pins.ss_oe = PIN_FUNC_SEL_IN & spi_on & master
                        & s.ctrl2[ssp_pkg::SELECT_PIN_ENABLE_BIT];
    next_s.irq = |(next_s.ist & next_s.ien);
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      s <= '0;
      s.ctrl0 <= ssp_pkg::CTRL0_RST;
      s.ctrl2 <= ssp_pkg::CTRL2_RST;
      s.shreg <= ssp_pkg::DATA_RST;
      s.ien <= ssp_pkg::IEN_RST;
      s.sck_lvl <= 1'h1;
      s.pins.sck <= 1'h1;
      s.sck_prev <= 1'h1;
      s.ss_prev <= 1'h1;
      s.pins.ss_n <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a flip-flop of the state, except the top 24 read data bits, which are tied to zero.
  assign PRDATA_OUT = {24'h000000, s.prdata};
  assign PREADY_OUT = s.pready;
  assign PSLVERR_OUT = s.pslverr;
  assign SDO_OUT = s.pins.sdo;
  assign SDO_OE_OUT = s.pins.sdo_oe;
  assign SCK_OUT = s.pins.sck;
  assign SCK_OE_OUT = s.pins.sck_oe;
  assign SLAVE_SELECT_N_OUT = s.pins.ss_n;
  assign SLAVE_SELECT_N_OE_OUT = s.pins.ss_oe;
  assign IRQ_OUT = s.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the logic above.
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  sequence seq_data_write;
    wr && PADDR_IN == ADDR_W'(ssp_pkg::OFF_DATA);
  endsequence

  sequence seq_master_last;
    master && spi_on && s.phase == ssp_pkg::SSP_RUN && hstep
      && s.edges == ssp_pkg::EDGE_TOTAL;
  endsequence

  chk_collision_flag: assert property (
    seq_data_write and busy |=> s.ctrl2[ssp_pkg::WRITE_COLLISION_FLAG_BIT] && s.ist[ssp_pkg::INT_COLL])
    else $error("Write during transfer did not flag a collision.");

  chk_done_flag: assert property (
    seq_master_last |=> s.ctrl2[ssp_pkg::TRF_BIT] && s.ist[ssp_pkg::INT_DONE]
      && s.irq == |(s.ist & s.ien))
    else $error("Finished transfer did not set the done flag.");

  chk_master_start: assert property (
    s.phase == ssp_pkg::SSP_IDLE && !master |=> s.phase == ssp_pkg::SSP_IDLE)
    else $error("Transfer started outside master role.");

  chk_eight_bits: assert property (
    $fell(s.phase == ssp_pkg::SSP_RUN) && $past(spi_on) && $past(master)
      |-> $past(s.edges) == ssp_pkg::EDGE_TOTAL)
    else $error("Master transfer ended without sixteen edges.");

  chk_clock_toggle: assert property (
    s.phase == ssp_pkg::SSP_RUN && hstep && spi_on && master
      && s.edges < ssp_pkg::EDGE_TOTAL |=> s.sck_lvl != $past(s.sck_lvl))
    else $error("Half period passed without a clock edge.");

  chk_idle_level: assert property (
    s.phase == ssp_pkg::SSP_IDLE ##1 s.phase == ssp_pkg::SSP_IDLE
      |=> s.pins.sck == ~$past(s.ctrl2[ssp_pkg::POL_BIT]))
    else $error("Idle clock level does not follow polarity.");

  chk_select_float: assert property (
    !s.ctrl2[ssp_pkg::SELECT_PIN_ENABLE_BIT] |=> !s.pins.ss_oe)
    else $error("Select pin driven with select enable cleared.");

  chk_pins_off: assert property (
    !PIN_FUNC_SEL_IN || !on |=> !s.pins.sdo_oe && !s.pins.sck_oe && !s.pins.ss_oe)
    else $error("Pins driven while port not selected or disabled.");

  chk_slave_abort: assert property (
    slave && on && s.ctrl2[ssp_pkg::SELECT_PIN_ENABLE_BIT] && ss_s && s.edges != 5'h0
      |=> s.ctrl0[ssp_pkg::INC_BIT] && s.ctrl2[ssp_pkg::TRF_BIT] && s.edges == 5'h0)
    else $error("Lifted select did not flag an incomplete byte.");

endmodule // ssp_port

// File: tb/ssp_slave_model.sv
`timescale 1ns/1ps
// Behavioural SPI slave that faces the port while the port is master.
module ssp_slave_model #(
  parameter int LAG_NS = 100
) (
  input wire logic sck_in, // Serial clock on the wire.
  input wire logic ss_n_in, // Select on the wire, active low.
  input wire logic mosi_in, // Data from the master.
  input wire logic idle_in, // Idle level of the clock.
  input wire logic lead_in, // High when data is captured on the leading edge.
  input wire logic [7:0] tx_in, // Byte to send, most significant bit first.
  output logic miso_out, // Data to the master.
  output logic [7:0] rx_out // Byte received, first bit in the top position.
);
  logic [7:0] txq = 8'h00;
  int idx = 0;
  initial miso_out = 1'b1;
  initial rx_out = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // Selection loads the byte; the slave never shifts before the master selects it.
  always @(negedge ss_n_in) begin
    txq = tx_in;
    idx = 0;
    miso_out <= #(LAG_NS) tx_in[7];
  end
  // A released line shows the inverse, so nothing can rely on a held value.
  always @(posedge ss_n_in) begin
    miso_out <= #(LAG_NS) ~miso_out;
  end
  // Each master clock edge moves one bit in or one bit out; the lag models a slow slave.
  always @(sck_in) begin
    if (ss_n_in === 1'b0) begin
      if ((sck_in !== idle_in) == lead_in) begin
        rx_out <= {rx_out[6:0], mosi_in};
      end else begin
        if (lead_in) idx = idx + 1;
        if (idx < 8) miso_out <= #(LAG_NS) txq[3'(7 - idx)];
        if (!lead_in) idx = idx + 1;
      end
    end
  end
endmodule // ssp_slave_model

// File: tb/ssp_port_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the serial port in master and slave role.
module ssp_port_tb;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pfs = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, prdata;
  logic rerr, pready, pslverr, sdo, sdo_oe, sck_o, sck_oe, ss_o, ss_oe, irq, miso;
  logic tb_sck = 1'b1, tb_ss_n = 1'b1, tb_mosi = 1'b0, slave_run = 1'b0;
  logic m_idle = 1'b1, m_lead = 1'b1, tb_tick = 1'b0, tb_match = 1'b0;
  logic [7:0] m_tx = 8'h00, m_rx;
  int error_cnt = 0, checks_done = 0;
  // The driving party sets each wire; the bench stands in for a master when none drives.
  wire logic sck_w = sck_oe ? sck_o : tb_sck;
  wire logic ss_w = ss_oe ? ss_o : tb_ss_n;
  wire logic sdi_w = slave_run ? tb_mosi : miso;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns.
  initial begin
    forever #20 clk = ~clk;
  end
  ssp_port dut (.MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PIN_FUNC_SEL_IN(pfs),
    .TIMEBASE_TICK_IN(tb_tick), .TIMER_MATCH_IN(tb_match), .SDI_IN(sdi_w), .SCK_IN(sck_w),
    .SLAVE_SELECT_N_IN(ss_w), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .SCK_OUT(sck_o),
    .SCK_OE_OUT(sck_oe), .SLAVE_SELECT_N_OUT(ss_o), .SLAVE_SELECT_N_OE_OUT(ss_oe),
    .IRQ_OUT(irq));
  ssp_slave_model #(.LAG_NS(100)) model (.sck_in(sck_w), .ss_n_in(ss_w), .mosi_in(sdo),
    .idle_in(m_idle), .lead_in(m_lead), .tx_in(m_tx), .miso_out(miso), .rx_out(m_rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // One APB transfer; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // Ready is judged as sampled at each rising edge; data and error come from that edge.
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, the read-only status and an unmapped address.
  task automatic t_reset;
    logic [7:0] adr[5] = '{ssp_pkg::OFF_CTRL0, ssp_pkg::OFF_CTRL2, ssp_pkg::OFF_DATA,
      ssp_pkg::OFF_ISTAT, ssp_pkg::OFF_IEN};
    logic [7:0] val[5] = '{ssp_pkg::CTRL0_RST, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(adr[i]);
      chk(rdat, 32'(val[i]));
    end
    rd(8'h18);
    chk(32'({rerr, rdat[7:0]}), 32'h100);
    chk(32'({sck_oe, sdo_oe, ss_oe}), 32'h0);
  endtask
  // A master byte at a divide by 16 with a collision and the done interrupt.
  task automatic t_master(input logic msb, input logic pol, input logic edg, input logic ie);
    logic [7:0] c2 = 8'h00;
    logic [7:0] sent = msb ? 8'h3A : 8'h51;
    int n = 0;
    c2[ssp_pkg::POL_BIT] = pol;
    c2[ssp_pkg::EDGE_BIT] = edg;
    c2[ssp_pkg::ORDER_BIT] = msb;
    c2[ssp_pkg::SELECT_PIN_ENABLE_BIT] = 1'b1;
    m_idle = ~pol;
    m_lead = edg;
    m_tx = msb ? 8'hC6 : 8'h2D;
    wr(ssp_pkg::OFF_IEN, 32'(ie));
    wr(ssp_pkg::OFF_CTRL2, 32'(c2));
    wr(ssp_pkg::OFF_CTRL0, 32'({ssp_pkg::SSP_DIV16, 5'h02}));
    repeat (3) @(negedge clk);
    chk(32'(sck_o), 32'({~pol}));
    wr(ssp_pkg::OFF_DATA, 32'(sent));
    wr(ssp_pkg::OFF_DATA, 32'hFF);
    chk(32'({ss_w, sck_oe, sdo_oe}), 32'h3);
    do begin
      rd(ssp_pkg::OFF_CTRL2);
      n++;
    end while (rdat[ssp_pkg::TRF_BIT] !== 1'b1 && n < 80);
    chk(32'(rdat[1:0]), 32'h3);
    chk(32'(irq), 32'(ie));
    chk(32'(ss_w), 32'h1);
    rd(ssp_pkg::OFF_DATA);
    chk(rdat, 32'(msb ? m_tx : rev8(m_tx)));
    chk(32'(m_rx), 32'(msb ? sent : rev8(sent)));
    wr(ssp_pkg::OFF_ICLR, 32'h7);
    wr(ssp_pkg::OFF_CTRL2, 32'(c2));
    rd(ssp_pkg::OFF_ISTAT);
    chk(32'({irq, rdat[2:0]}), 32'h0);
  endtask
  // Pin function, module enable and select enable gate the pin drivers.
  task automatic t_off;
    @(posedge clk);
    pfs <= 1'b0;
    repeat (3) @(negedge clk);
    chk(32'({sck_oe, sdo_oe, ss_oe}), 32'h0);
    @(posedge clk);
    pfs <= 1'b1;
    wr(ssp_pkg::OFF_CTRL0, 32'({ssp_pkg::SSP_TWOWIRE, 5'h02}));
    repeat (3) @(negedge clk);
    chk(32'({sck_oe, sdo_oe, ss_oe}), 32'h0);
    wr(ssp_pkg::OFF_CTRL0, 32'({ssp_pkg::SSP_DIV4, 5'h00}));
    repeat (3) @(negedge clk);
    chk(32'({sck_oe, sdo_oe, ss_oe}), 32'h0);
    rd(ssp_pkg::OFF_CTRL2);
    chk(rdat, 32'h24);
    wr(ssp_pkg::OFF_CTRL2, 32'h0);
    wr(ssp_pkg::OFF_CTRL0, 32'({ssp_pkg::SSP_DIV4, 5'h02}));
    repeat (3) @(negedge clk);
    chk(32'({sck_oe, ss_oe}), 32'h2);
  endtask
  // Slave role: no clock of its own and no start until the bench clocks a byte in.
  task automatic t_slave;
    logic [7:0] got;
    logic [7:0] mo = 8'h5B;
    wr(ssp_pkg::OFF_CTRL2, 32'h1C);
    wr(ssp_pkg::OFF_CTRL0, 32'({ssp_pkg::SSP_SLAVE, 5'h02}));
    wr(ssp_pkg::OFF_DATA, 32'h96);
    repeat (40) @(negedge clk);
    chk(32'({sck_oe, ss_oe}), 32'h0);
    rd(ssp_pkg::OFF_CTRL2);
    chk(32'(rdat[ssp_pkg::TRF_BIT]), 32'h0);
    @(posedge clk);
    slave_run <= 1'b1;
    tb_ss_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tb_mosi <= mo[7 - i];
      repeat (8) @(posedge clk);
      got[7 - i] = sdo;
      tb_sck <= 1'b0;
      repeat (8) @(posedge clk);
      tb_sck <= 1'b1;
    end
    repeat (8) @(posedge clk);
    tb_ss_n <= 1'b1;
    slave_run <= 1'b0;
    chk(32'(got), 32'h96);
    rd(ssp_pkg::OFF_DATA);
    chk(rdat, 32'h5B);
    rd(ssp_pkg::OFF_CTRL2);
    chk(32'(rdat[ssp_pkg::TRF_BIT]), 32'h1);
    // Select lifted after two edges: the byte is flagged incomplete and done.
    wr(ssp_pkg::OFF_ICLR, 32'h7);
    @(posedge clk);
    tb_ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    tb_sck <= 1'b0;
    repeat (8) @(posedge clk);
    tb_sck <= 1'b1;
    repeat (8) @(posedge clk);
    tb_ss_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ssp_pkg::OFF_CTRL0);
    chk(rdat, 32'hA3);
    rd(ssp_pkg::OFF_ISTAT);
    chk(rdat, 32'h5);
  endtask
  // Timebase and timer-match modes move the clock only on pulses of the chosen source.
  task automatic t_tick(input logic use_match);
    ssp_pkg::ssp_mode_t md = use_match ? ssp_pkg::SSP_TMATCH : ssp_pkg::SSP_TBASE;
    m_idle = 1'b1;
    m_lead = 1'b1;
    wr(ssp_pkg::OFF_CTRL2, 32'h1C);
    wr(ssp_pkg::OFF_CTRL0, 32'({md, 5'h02}));
    wr(ssp_pkg::OFF_DATA, 32'hA5);
    // Three pulses of the other source first, then sixteen edges and one closing half period.
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      tb_tick <= (i < 3) ? use_match : ~use_match;
      tb_match <= (i < 3) ? ~use_match : use_match;
      @(posedge clk);
      tb_tick <= 1'b0;
      tb_match <= 1'b0;
      repeat (7) @(posedge clk);
      if (i == 2) chk(32'({ss_w, sck_o}), 32'h1);
    end
    repeat (4) @(posedge clk);
    rd(ssp_pkg::OFF_CTRL2);
    chk(32'(rdat[ssp_pkg::TRF_BIT]), 32'h1);
    rd(ssp_pkg::OFF_DATA);
    chk(rdat, 32'(m_tx));
    chk(32'(m_rx), 32'hA5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_master(1'b1, 1'b0, 1'b1, 1'b1);
    t_master(1'b0, 1'b1, 1'b0, 1'b0);
    t_off;
    t_tick(1'b0);
    t_tick(1'b1);
    t_slave;
    print_verdict;
  end
  // The whole run needs about a thousand cycles; this limit only cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
endmodule // ssp_port_tb
